//--- src/dmc_map.svh
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
`define DMC_NCH 8
`define DMC_NBUS 3
`define DMC_BUS_SYS 2'h0
`define DMC_BUS_DMA 2'h1
`define DMC_BUS_LINK 2'h2
`define DMC_RGN_HI 31
`define DMC_RGN_LO 28
`define DMC_RGN_DMA 4'he
`define DMC_RGN_LINK 4'hf
`define DMC_CHK_IN_ADDR 32'hf000_0000
`define DMC_CHK_SEED 32'hffff_ffff
`define DMC_POLY 32'h04c1_1db7
`define DMC_W8 2'h0
`define DMC_W16 2'h1
`define DMC_W32 2'h2
`define DMC_AM_KEEP 2'h0
`define DMC_AM_INC 2'h1
`define DMC_AM_DEC 2'h2
`define DMC_BUF_DEPTH 2
`define DMC_NLINK 2
`endif

//--- src/dmc_pkg.sv
`include "dmc_map.svh"
package dmc_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_rd = 4'h2,
    st_rw = 4'h4,
    st_wr = 4'h8
  } dmc_state_e;

  typedef struct packed {
    logic en;
    logic cont;
    logic hw_en;
    logic [2:0] req_sel;
    logic prio;
    logic [1:0] width;
    logic [1:0] src_mod;
    logic [1:0] dst_mod;
    logic [4:0] circ;
    logic srq_en;
  } dmc_ctl_s;

  typedef struct packed {
    dmc_ctl_s ctl;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] cnt;
  } dmc_chcfg_s;

  typedef struct packed {
    logic we;
    logic tag;
    logic [1:0] size;
    logic [1:0] prio;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmc_breq_s;

  typedef struct packed {
    logic tag;
    logic [31:0] rdata;
  } dmc_brsp_s;
endpackage

//--- src/dmc_pipe2.sv
`timescale 1ns/1ps
module dmc_pipe2 #(
  parameter int W = 8,
  parameter int D = 2
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= inc(wp_q);
      if (pop) rp_q <= inc(rp_q);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) mem_q[wp_q] <= in_data;
  end

  AST_BUF_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffered move lost while stalled");
endmodule

//--- src/dmc_crc.sv
`timescale 1ns/1ps
`include "dmc_map.svh"
module dmc_crc (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic init,
  input wire logic wr,
  input wire logic [1:0] size,
  input wire logic [31:0] data,
  output logic [31:0] result_q
);
  // MSB-first shift, no bit reversal and no final inversion: unlike the frame check
  function automatic logic [31:0] step(input logic [31:0] c_in, input logic [31:0] d,
                                       input logic [1:0] sz);
    logic [31:0] c;
    logic fb;
    int nb;
    c = c_in;
    fb = 1'b0;
    nb = (sz == `DMC_W8) ? 8 : (sz == `DMC_W16) ? 16 : 32;
    for (int i = 31; i >= 0; i--) begin
      if (i < nb) begin
        fb = c[31] ^ d[i];
        c = {c[30:0], 1'b0} ^ (fb ? `DMC_POLY : 32'h0000_0000);
      end
    end
    return c;
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) result_q <= `DMC_CHK_SEED;
    else if (init) result_q <= `DMC_CHK_SEED;
    else if (wr) result_q <= step(result_q, data, size);
  end

  AST_CHK_ONLY_ON_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !wr && !init |=> $stable(result_q))
    else $error("checksum changed without a write");
endmodule

//--- src/dmc_top.sv
`timescale 1ns/1ps
`include "dmc_map.svh"
// Function
// - Eight channels, each moving source to destination
// - Channel picks one of eight hardware requests
// - Two priority levels arbitrate among channels
// - Software or selected hardware request starts move
// - Single mode clears enable after last transfer
// - Continuous mode stays enabled and reloads count
// - Addresses step, hold or wrap circularly
// - Full 32-bit source and destination addresses
// - Move width is 8, 16 or 32 bits
// - Per-channel address, control, status, count registers
// - At least one move buffered per bus
// - Sub-block bus priority is programmable per bus
// - Switch feeds system bus, DMA bus and link bus
// - Sole master on DMA bus, bridges system requests
// - All buses share one clock
// - Channel and link service request outputs
// - Checker write updates the stored checksum
// - Checksum uses the 32-bit standard polynomial
// - Checksum algorithm differs from frame check
module dmc_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_ch,
  input wire dmc_pkg::dmc_chcfg_s cfg,
  input wire logic [`DMC_NCH-1:0] sw_req,
  input wire logic [`DMC_NCH-1:0] hw_req,
  input wire logic [`DMC_NCH-1:0] done_clr,
  input wire logic [`DMC_NBUS-1:0][1:0] bus_prio,
  output logic [`DMC_NBUS-1:0] bus_req_valid,
  input wire logic [`DMC_NBUS-1:0] bus_req_ready,
  output dmc_pkg::dmc_breq_s [`DMC_NBUS-1:0] bus_req,
  input wire logic [`DMC_NBUS-1:0] bus_rsp_valid,
  input wire dmc_pkg::dmc_brsp_s [`DMC_NBUS-1:0] bus_rsp,
  input wire logic br_valid,
  output logic br_ready,
  input wire dmc_pkg::dmc_breq_s br_req,
  output logic br_rsp_valid,
  output logic [31:0] br_rsp_data,
  output logic [`DMC_NCH-1:0] chan_en,
  output logic [`DMC_NCH-1:0] chan_done,
  output logic [`DMC_NCH-1:0] chan_srq,
  input wire logic [`DMC_NLINK-1:0] link_evt,
  input wire logic [`DMC_NLINK-1:0] link_clr,
  input wire logic [`DMC_NLINK-1:0] link_srq_en,
  output logic [`DMC_NLINK-1:0] link_srq,
  input wire logic chk_init,
  output logic [31:0] chk_result
);
  // ==========================================================
  // Helpers
  function automatic logic [2:0] first_set(input logic [`DMC_NCH-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = `DMC_NCH - 1; i >= 0; i--) begin
      if (v[i]) r = 3'(i);
    end
    return r;
  endfunction

  function automatic logic [1:0] bus_of(input logic [31:0] a);
    logic [3:0] rgn;
    rgn = a[`DMC_RGN_HI:`DMC_RGN_LO];
    if (rgn == `DMC_RGN_LINK) return `DMC_BUS_LINK;
    if (rgn == `DMC_RGN_DMA) return `DMC_BUS_DMA;
    return `DMC_BUS_SYS;
  endfunction

  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [1:0] m,
                                            input logic [4:0] circ, input logic [1:0] w);
    logic [31:0] stp, sum, msk;
    stp = 32'h0000_0001 << w;
    sum = (m == `DMC_AM_INC) ? a + stp : (m == `DMC_AM_DEC) ? a - stp : a;
    msk = (circ == 5'h00) ? 32'hffff_ffff : (32'h0000_0001 << circ) - 32'h0000_0001;
    return (a & ~msk) | (sum & msk);
  endfunction

  function automatic logic [31:0] width_mask(input logic [1:0] w);
    return (w == `DMC_W8) ? 32'h0000_00ff : (w == `DMC_W16) ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction

  // ==========================================================
  // Channel register set
  dmc_pkg::dmc_ctl_s ctl_q [`DMC_NCH];
  dmc_pkg::dmc_ctl_s ctl_d [`DMC_NCH];
  logic [31:0] src_q [`DMC_NCH];
  logic [31:0] src_d [`DMC_NCH];
  logic [31:0] dst_q [`DMC_NCH];
  logic [31:0] dst_d [`DMC_NCH];
  logic [15:0] cnt_q [`DMC_NCH];
  logic [15:0] cnt_d [`DMC_NCH];
  logic [15:0] rld_q [`DMC_NCH];
  logic [15:0] rld_d [`DMC_NCH];
  logic [`DMC_NCH-1:0] done_q, done_d, pend_q, pend_d, req_set, cand, hi_cand, gnt, en_v;
  logic [`DMC_NLINK-1:0] link_q;

  dmc_pkg::dmc_state_e st_q, st_d;
  logic [2:0] cur_q, pick;
  logic [31:0] dat_q;
  logic [31:0] br_dat_q;
  logic br_rv_q;

  // ==========================================================
  // Request capture and arbitration
  genvar c;
  generate
    for (c = 0; c < `DMC_NCH; c++) begin : g_req
      assign en_v[c] = ctl_q[c].en;
      assign req_set[c] = sw_req[c] || (ctl_q[c].hw_en && hw_req[ctl_q[c].req_sel]);
      assign hi_cand[c] = cand[c] && ctl_q[c].prio;
    end
  endgenerate

  assign cand = en_v & pend_q;
  assign pick = (|hi_cand) ? first_set(hi_cand) : first_set(cand);
  wire start = (st_q == dmc_pkg::st_idle) && (|cand);
  assign gnt = start ? (`DMC_NCH'(1) << pick) : '0;

  // ==========================================================
  // Move engine
  dmc_pkg::dmc_ctl_s cur_ctl;
  assign cur_ctl = ctl_q[cur_q];
  wire [1:0] sbus = bus_of(src_q[cur_q]);
  wire [1:0] dbus = bus_of(dst_q[cur_q]);
  wire is_wr = (st_q == dmc_pkg::st_wr);
  wire eng_v = (st_q == dmc_pkg::st_rd) || is_wr;
  wire [1:0] eng_bus = is_wr ? dbus : sbus;
  // Engine goes ahead of bridged traffic on the DMA bus when its priority is nonzero
  wire eng_first = !br_valid || (bus_prio[`DMC_BUS_DMA] != 2'h0);
  logic [`DMC_NBUS-1:0] fi_v, fi_r, fo_v, fo_r;
  dmc_pkg::dmc_breq_s fi_d [`DMC_NBUS];
  dmc_pkg::dmc_breq_s fo_d [`DMC_NBUS];
  dmc_pkg::dmc_breq_s eng_rq, br_rq;
  wire eng_on_dma = eng_v && (eng_bus == `DMC_BUS_DMA);
  wire eng_take = eng_v && fi_r[eng_bus] && (!eng_on_dma || eng_first);
  wire rsp_ok = bus_rsp_valid[sbus] && !bus_rsp[sbus].tag;
  wire fin = is_wr && eng_take;
  wire last = (cnt_q[cur_q] <= 16'h0001);

  assign eng_rq = '{we: is_wr, tag: 1'b0, size: cur_ctl.width, prio: bus_prio[eng_bus],
                    addr: is_wr ? dst_q[cur_q] : src_q[cur_q],
                    wdata: is_wr ? dat_q : 32'h0000_0000};
  assign br_rq = '{we: br_req.we, tag: 1'b1, size: br_req.size,
                   prio: bus_prio[`DMC_BUS_DMA], addr: br_req.addr, wdata: br_req.wdata};
  assign br_ready = fi_r[`DMC_BUS_DMA] && !(eng_on_dma && eng_first);

  always_comb begin
    st_d = st_q;
    case (st_q)
      dmc_pkg::st_idle: if (start) st_d = dmc_pkg::st_rd;
      dmc_pkg::st_rd: if (eng_take) st_d = dmc_pkg::st_rw;
      dmc_pkg::st_rw: if (rsp_ok) st_d = dmc_pkg::st_wr;
      dmc_pkg::st_wr: if (eng_take) st_d = dmc_pkg::st_idle;
      default: st_d = dmc_pkg::st_idle;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= dmc_pkg::st_idle;
      cur_q <= 3'h0;
      dat_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      if (start) cur_q <= pick;
      if (st_q == dmc_pkg::st_rw && rsp_ok) dat_q <= bus_rsp[sbus].rdata & width_mask(cur_ctl.width);
    end
  end

  // ==========================================================
  // Channel register next values
  wire [31:0] nxt_src = next_addr(src_q[cur_q], cur_ctl.src_mod, cur_ctl.circ, cur_ctl.width);
  wire [31:0] nxt_dst = next_addr(dst_q[cur_q], cur_ctl.dst_mod, cur_ctl.circ, cur_ctl.width);

  always_comb begin
    for (int i = 0; i < `DMC_NCH; i++) begin
      ctl_d[i] = ctl_q[i];
      src_d[i] = src_q[i];
      dst_d[i] = dst_q[i];
      cnt_d[i] = cnt_q[i];
      rld_d[i] = rld_q[i];
      done_d[i] = done_q[i] && !done_clr[i];
      if (fin && cur_q == 3'(i)) begin
        src_d[i] = nxt_src;
        dst_d[i] = nxt_dst;
        if (last) begin
          done_d[i] = 1'b1;
          if (ctl_q[i].cont) begin
            cnt_d[i] = rld_q[i];
          end else begin
            ctl_d[i].en = 1'b0;
            cnt_d[i] = 16'h0000;
          end
        end else begin
          cnt_d[i] = cnt_q[i] - 16'h0001;
        end
      end
      // Reprogramming overrides a move finishing in the same cycle, except that the move still sets its done flag
      if (cfg_wr && cfg_ch == 3'(i)) begin
        ctl_d[i] = cfg.ctl;
        src_d[i] = cfg.src;
        dst_d[i] = cfg.dst;
        cnt_d[i] = cfg.cnt;
        rld_d[i] = cfg.cnt;
      end
      pend_d[i] = ctl_q[i].en && (req_set[i] || (pend_q[i] && !gnt[i]));
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `DMC_NCH; i++) begin
        ctl_q[i] <= '0;
        src_q[i] <= 32'h0000_0000;
        dst_q[i] <= 32'h0000_0000;
        cnt_q[i] <= 16'h0000;
        rld_q[i] <= 16'h0000;
      end
      done_q <= '0;
      pend_q <= '0;
    end else begin
      for (int i = 0; i < `DMC_NCH; i++) begin
        ctl_q[i] <= ctl_d[i];
        src_q[i] <= src_d[i];
        dst_q[i] <= dst_d[i];
        cnt_q[i] <= cnt_d[i];
        rld_q[i] <= rld_d[i];
      end
      done_q <= done_d;
      pend_q <= pend_d;
    end
  end

  // ==========================================================
  // Bus switch: one two-entry buffer per bus
  genvar b;
  generate
    for (b = 0; b < `DMC_NBUS; b++) begin : g_bus
      wire eng_here = eng_v && (eng_bus == 2'(b));
      wire br_here = (2'(b) == `DMC_BUS_DMA) && br_valid;
      assign fi_v[b] = (eng_here && (!br_here || eng_first)) || br_here;
      assign fi_d[b] = (br_here && !(eng_here && eng_first)) ? br_rq : eng_rq;
      dmc_pipe2 #(.W($bits(dmc_pkg::dmc_breq_s)), .D(`DMC_BUF_DEPTH)) u_buf (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(fi_v[b]),
        .in_ready(fi_r[b]),
        .in_data(fi_d[b]),
        .out_valid(fo_v[b]),
        .out_ready(fo_r[b]),
        .out_data(fo_d[b])
      );
      assign bus_req[b] = fo_d[b];
    end
  endgenerate

  // Checker input writes are taken off the link bus and never leave the block
  wire to_chk = fo_d[`DMC_BUS_LINK].we && (fo_d[`DMC_BUS_LINK].addr == `DMC_CHK_IN_ADDR);
  wire chk_wr = fo_v[`DMC_BUS_LINK] && to_chk;
  assign bus_req_valid[`DMC_BUS_SYS] = fo_v[`DMC_BUS_SYS];
  assign bus_req_valid[`DMC_BUS_DMA] = fo_v[`DMC_BUS_DMA];
  assign bus_req_valid[`DMC_BUS_LINK] = fo_v[`DMC_BUS_LINK] && !to_chk;
  assign fo_r[`DMC_BUS_SYS] = bus_req_ready[`DMC_BUS_SYS];
  assign fo_r[`DMC_BUS_DMA] = bus_req_ready[`DMC_BUS_DMA];
  assign fo_r[`DMC_BUS_LINK] = to_chk || bus_req_ready[`DMC_BUS_LINK];

  dmc_crc u_crc (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .init(chk_init),
    .wr(chk_wr),
    .size(fo_d[`DMC_BUS_LINK].size),
    .data(fo_d[`DMC_BUS_LINK].wdata),
    .result_q(chk_result)
  );

  // ==========================================================
  // Bridge answers and service requests
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      br_rv_q <= 1'b0;
      br_dat_q <= 32'h0000_0000;
      link_q <= '0;
    end else begin
      br_rv_q <= bus_rsp_valid[`DMC_BUS_DMA] && bus_rsp[`DMC_BUS_DMA].tag;
      if (bus_rsp_valid[`DMC_BUS_DMA]) br_dat_q <= bus_rsp[`DMC_BUS_DMA].rdata;
      link_q <= (link_q & ~link_clr) | link_evt;
    end
  end

  assign br_rsp_valid = br_rv_q;
  assign br_rsp_data = br_dat_q;
  assign chan_en = en_v;
  assign chan_done = done_q;
  generate
    for (c = 0; c < `DMC_NCH; c++) begin : g_srq
      assign chan_srq[c] = done_q[c] && ctl_q[c].srq_en;
    end
  endgenerate
  assign link_srq = link_q & link_srq_en;

  // ==========================================================
  // Checks
  wire no_cfg_cur = !(cfg_wr && cfg_ch == cur_q);

  AST_START_ON_REQUEST: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == dmc_pkg::st_idle && (|cand) |=> st_q == dmc_pkg::st_rd &&
    (!$past(pend_d[pick]) || $past(req_set[pick])))
    else $error("channel started without a pending request");
  AST_HIGH_PRIO_FIRST: assert property (@(posedge ref_clk) disable iff (!reset_n)
    start && (|hi_cand) |=> ctl_q[cur_q].prio || $past(cfg_wr))
    else $error("low priority channel won over a high one");
  AST_READ_BEFORE_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == dmc_pkg::st_rw && rsp_ok |=> st_q == dmc_pkg::st_wr ##0 eng_rq.wdata == $past(
    bus_rsp[sbus].rdata & width_mask(cur_ctl.width)))
    else $error("write does not carry the data read");
  AST_SINGLE_STOPS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fin && last && !cur_ctl.cont && no_cfg_cur |=> !chan_en[cur_q] && cnt_q[cur_q] == 16'h0000)
    else $error("single mode channel still enabled after last move");
  AST_CONT_RELOADS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fin && last && cur_ctl.cont && no_cfg_cur |=> chan_en[cur_q] && cnt_q[cur_q] == rld_q[cur_q])
    else $error("continuous channel not reloaded");
  AST_DONE_FLAG: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fin && last |=> chan_done[cur_q] ##1 (chan_done[$past(cur_q)] || $past(done_clr[cur_q])))
    else $error("done flag missing after last move");
  AST_CHK_ALWAYS_TAKES: assert property (@(posedge ref_clk) disable iff (!reset_n)
    chk_wr |-> fo_r[`DMC_BUS_LINK] && !bus_req_valid[`DMC_BUS_LINK])
    else $error("checker write leaked onto the link bus");
  AST_BRIDGE_TAGGED: assert property (@(posedge ref_clk) disable iff (!reset_n)
    br_valid && br_ready |-> fi_v[`DMC_BUS_DMA] && fi_d[`DMC_BUS_DMA].tag)
    else $error("bridged request not routed to the DMA bus");
  AST_DEC_STEP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fin && cur_ctl.src_mod == `DMC_AM_DEC && cur_ctl.circ == 5'h00 && no_cfg_cur |=>
    src_q[cur_q] == $past(src_q[cur_q]) - (32'h0000_0001 << $past(cur_ctl.width)))
    else $error("source address step wrong");

  COV_SINGLE_DONE: cover property (@(posedge ref_clk) disable iff (!reset_n)
    fin && last && !cur_ctl.cont);
  COV_CONT_RELOAD: cover property (@(posedge ref_clk) disable iff (!reset_n)
    fin && last && cur_ctl.cont);
  COV_CHK_WRITE: cover property (@(posedge ref_clk) disable iff (!reset_n) chk_wr);
  COV_BRIDGE_BLOCKED: cover property (@(posedge ref_clk) disable iff (!reset_n)
    br_valid && !br_ready && eng_on_dma);
endmodule

//--- testbench/dmc_bus_model.sv
`timescale 1ns/1ps
// ====================
// Far-side bus: pattern memory for reads, last write logged
module dmc_bus_model #(
  parameter int LAT = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic stall,
  input wire logic req_valid,
  output logic req_ready,
  input wire dmc_pkg::dmc_breq_s req,
  output logic rsp_valid,
  output dmc_pkg::dmc_brsp_s rsp,
  output int n_wr,
  output logic [31:0] w_addr,
  output logic [31:0] w_data
);
  dmc_pkg::dmc_brsp_s q[$];
  int d;
  assign req_ready = !stall;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q.delete();
      d = 0;
      n_wr <= 0;
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= 1'b0;
      // Idle data toggles so a stale word never passes for an answer
      rsp.rdata <= ~rsp.rdata;
      if (req_valid && !stall) begin
        if (req.we) begin
          n_wr <= n_wr + 1;
          w_addr <= req.addr;
          w_data <= req.wdata;
        end else begin
          q.push_back({req.tag, req.addr[15:0] ^ 16'ha5c3, req.addr[15:0]});
        end
      end
      d = (q.size() > 0) ? d + 1 : 0;
      if (d >= LAT) begin
        rsp_valid <= 1'b1;
        rsp <= q.pop_front();
        d = 0;
      end
    end
  end
endmodule

//--- testbench/test_dmc_top.sv
`timescale 1ns/1ps
module test_dmc_top;
  logic ref_clk, reset_n, cfg_wr, br_valid, br_ready, br_rsp_valid, chk_init;
  logic [2:0] cfg_ch, bus_req_valid, stall;
  wire [2:0] bus_req_ready, bus_rsp_valid;
  wire dmc_pkg::dmc_brsp_s [2:0] bus_rsp;
  dmc_pkg::dmc_chcfg_s cfg;
  logic [7:0] sw_req, hw_req, done_clr, chan_en, chan_done, chan_srq;
  dmc_pkg::dmc_breq_s [2:0] bus_req;
  dmc_pkg::dmc_breq_s br_req;
  logic [2:0][1:0] bus_prio;
  logic [31:0] br_rsp_data, chk_result, e, s, m;
  logic [1:0] link_evt, link_clr, link_srq_en, link_srq;
  logic [31:0] w_addr[3], w_data[3];
  int errors, samples_checked, n_wr[3], n0;

  dmc_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_ch(cfg_ch),
    .cfg(cfg), .sw_req(sw_req), .hw_req(hw_req), .done_clr(done_clr),
    .bus_prio(bus_prio), .bus_req_valid(bus_req_valid),
    .bus_req_ready(bus_req_ready), .bus_req(bus_req), .bus_rsp_valid(bus_rsp_valid),
    .bus_rsp(bus_rsp), .br_valid(br_valid), .br_ready(br_ready), .br_req(br_req),
    .br_rsp_valid(br_rsp_valid), .br_rsp_data(br_rsp_data), .chan_en(chan_en),
    .chan_done(chan_done), .chan_srq(chan_srq), .link_evt(link_evt), .link_clr(link_clr),
    .link_srq_en(link_srq_en), .link_srq(link_srq), .chk_init(chk_init),
    .chk_result(chk_result));

  for (genvar i = 0; i < 3; i++) begin : g_bus
    dmc_bus_model #(.LAT(i + 1)) u_bus (.ref_clk(ref_clk), .reset_n(reset_n),
      .stall(stall[i]), .req_valid(bus_req_valid[i]), .req_ready(bus_req_ready[i]),
      .req(bus_req[i]), .rsp_valid(bus_rsp_valid[i]), .rsp(bus_rsp[i]), .n_wr(n_wr[i]),
      .w_addr(w_addr[i]), .w_data(w_data[i]));
  end

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ====================
  // Helpers
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0] ^ 16'ha5c3, a[15:0]};
  endfunction

  // MSB first, no reflection or final inversion
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] v);
    for (int i = 31; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ v[i]) ? 32'h04c1_1db7 : 32'h0);
    return c;
  endfunction

  function automatic dmc_pkg::dmc_ctl_s mk(input logic en, cont, hw, input logic [2:0] sel,
      input logic pr, input logic [1:0] w, sm, dm, input logic [4:0] circ);
    return {en, cont, hw, sel, pr, w, sm, dm, circ, 1'b1};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic setup(input int ch, input dmc_pkg::dmc_ctl_s c, input logic [31:0] sa,
      input logic [31:0] da, input logic [15:0] n);
    @(negedge ref_clk);
    cfg_wr = 1'b1;
    cfg_ch = ch[2:0];
    cfg = {c, sa, da, n};
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask

  task automatic pulse_sw(input logic [7:0] v);
    @(negedge ref_clk);
    sw_req = v;
    @(negedge ref_clk);
    sw_req = '0;
  endtask

  task automatic wait_wr(input int b, input int n);
    for (int k = 0; k < 300 && n_wr[b] < n; k++) @(negedge ref_clk);
    check(n_wr[b], n);
  endtask

  initial begin
    #500000;
    errors++;
    results();
  end

  // ====================
  // Tests
  initial begin
    errors = 0;
    samples_checked = 0;
    {reset_n, cfg_wr, cfg_ch, cfg, sw_req, hw_req, done_clr, stall} = '0;
    {br_valid, br_req, link_evt, link_clr, link_srq_en, chk_init} = '0;
    bus_prio = {2'h3, 2'h2, 2'h1};
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    check({bus_req_valid, br_rsp_valid, chan_en, chan_done}, 0);
    check(chk_result, 32'hffff_ffff);
    // Each width: two stepped moves, the second held up by a stalled bus
    for (int w = 0; w < 3; w++) begin
      s = 32'h0000_1000 + 32'(w) * 32'h100;
      m = (w == 0) ? 32'hff : (w == 1) ? 32'hffff : 32'hffff_ffff;
      setup(w, mk(1, 0, 0, 0, 0, w[1:0], 2'h1, 2'h1, 0), s, 32'he000_0100, 16'h2);
      n0 = n_wr[1];
      pulse_sw(8'h1 << w);
      wait_wr(1, n0 + 1);
      check(w_addr[1], 32'he000_0100);
      check(w_data[1], pat(s) & m);
      stall[1] = 1'b1;
      pulse_sw(8'h1 << w);
      repeat (12) @(negedge ref_clk);
      check(bus_req_valid[1], 1'b1);
      check(n_wr[1], n0 + 1);
      check(bus_req[1].prio, 2'h2);
      stall[1] = 1'b0;
      wait_wr(1, n0 + 2);
      check(w_addr[1], 32'he000_0100 + (32'h1 << w));
      check(w_data[1], pat(s + (32'h1 << w)) & m);
      check({chan_en[w], chan_done[w], chan_srq[w]}, 3'b011);
      pulse_sw(8'h1 << w);
      repeat (20) @(negedge ref_clk);
      check(n_wr[1], n0 + 2);
      done_clr = 8'h1 << w;
      @(negedge ref_clk);
      done_clr = '0;
      @(negedge ref_clk);
      check(chan_done[w], 1'b0);
    end
    // Hardware trigger, continuous mode, circular destination
    setup(5, mk(1, 1, 1, 3'h3, 0, 2'h1, 2'h0, 2'h1, 5'h3), 32'h2000, 32'he000_0036, 16'h2);
    n0 = n_wr[1];
    hw_req = 8'h10;
    repeat (20) @(negedge ref_clk);
    check(n_wr[1], n0);
    hw_req = 8'h08;
    wait_wr(1, n0 + 1);
    check(w_addr[1], 32'he000_0036);
    check(w_data[1], pat(32'h2000) & 32'hffff);
    wait_wr(1, n0 + 2);
    hw_req = '0;
    check(w_addr[1], 32'he000_0030);
    check({chan_en[5], chan_done[5]}, 2'b11);
    setup(5, mk(0, 1, 1, 3'h3, 0, 2'h1, 2'h0, 2'h1, 5'h3), 32'h2000, 32'he000_0036, 16'h2);
    repeat (20) @(negedge ref_clk);
    // Two channels requested together: higher level goes first
    setup(1, mk(1, 0, 0, 0, 0, 2'h2, 2'h2, 2'h0, 0), 32'h0400, 32'he000_0500, 16'h1);
    setup(6, mk(1, 0, 0, 0, 1, 2'h2, 2'h0, 2'h0, 0), 32'h0600, 32'he000_0700, 16'h1);
    n0 = n_wr[1];
    pulse_sw(8'h42);
    wait_wr(1, n0 + 1);
    check(w_addr[1], 32'he000_0700);
    wait_wr(1, n0 + 2);
    check(w_addr[1], 32'he000_0500);
    // Link-bus source words fed into the checksum unit
    chk_init = 1'b1;
    @(negedge ref_clk);
    chk_init = 1'b0;
    setup(7, mk(1, 0, 0, 0, 0, 2'h2, 2'h1, 2'h0, 0), 32'hf000_0100, 32'hf000_0000, 16'h2);
    e = 32'hffff_ffff;
    for (int k = 0; k < 2; k++) begin
      e = crc(e, pat(32'hf000_0100 + 32'(k) * 4));
      pulse_sw(8'h80);
      for (int t = 0; t < 100 && chk_result !== e; t++) @(negedge ref_clk);
      check(chk_result, e);
    end
    check(n_wr[2], 0);
    // System-side read bridged onto the DMA bus
    @(negedge ref_clk);
    br_req = {1'b0, 1'b0, 2'h2, 2'h0, 32'he000_0040, 32'h0};
    br_valid = 1'b1;
    #1;
    for (int t = 0; t < 50 && br_ready !== 1'b1; t++) @(negedge ref_clk);
    @(negedge ref_clk);
    br_valid = 1'b0;
    for (int t = 0; t < 50 && br_rsp_valid !== 1'b1; t++) @(negedge ref_clk);
    check(br_rsp_valid, 1'b1);
    check(br_rsp_data, pat(32'he000_0040));
    // Link service request nodes
    link_srq_en = 2'b01;
    link_evt = 2'b11;
    @(negedge ref_clk);
    link_evt = 2'b00;
    repeat (2) @(negedge ref_clk);
    check(link_srq, 2'b01);
    link_clr = 2'b01;
    @(negedge ref_clk);
    link_clr = 2'b00;
    repeat (2) @(negedge ref_clk);
    check(link_srq, 2'b00);
    results();
  end
endmodule
